/* common/adc_pkg.sv */
// constants, types and register map of the converter control block
package adc_pkg;
    localparam int RES_W = 10;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RES_LO = 8'h78;
    localparam logic [7:0] IDX_RES_HI = 8'h79;
    localparam logic [7:0] IDX_CTRL = 8'h7a;
    localparam logic [7:0] IDX_TRIG = 8'h7b;
    localparam logic [7:0] IDX_CHAN = 8'h7c;
    localparam logic [11:0] ADDR_RES_LO = {2'h0, IDX_RES_LO, 2'h0};
    localparam logic [11:0] ADDR_RES_HI = {2'h0, IDX_RES_HI, 2'h0};
    localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_TRIG = {2'h0, IDX_TRIG, 2'h0};
    localparam logic [11:0] ADDR_CHAN = {2'h0, IDX_CHAN, 2'h0};
    // control/status fields
    localparam int CTRL_ON = 7;
    localparam int CTRL_START = 6;
    localparam int CTRL_AUTO = 5;
    localparam int CTRL_FLAG = 4;
    localparam int CTRL_IRQ = 3;
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 2;
    // channel select and trigger source fields
    localparam int CHAN_LEFT = 5;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 4;
    localparam int TRIG_MSB = 2;
    localparam logic [2:0] TRIG_FREE = 3'h0;
    // input select codes
    localparam logic [4:0] SEL_SE_LAST = 5'h07;
    localparam logic [4:0] SEL_GAIN_LAST = 5'h0f;
    localparam logic [4:0] SEL_NEG1_LAST = 5'h17;
    localparam logic [4:0] SEL_BANDGAP = 5'h1e;
    localparam logic [4:0] SEL_GROUND = 5'h1f;
    localparam logic [2:0] PIN_0 = 3'h0;
    localparam logic [2:0] PIN_1 = 3'h1;
    localparam logic [2:0] PIN_2 = 3'h2;
    // conversion lengths in converter clock cycles
    localparam logic [4:0] FIRST_CYCLES = 5'h19;
    localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
    // prescaler: last count value per divider code (divide by value + 1)
    localparam logic [6:0] DIV_LAST [8] = '{7'h01, 7'h01, 7'h03, 7'h07,
                                            7'h0f, 7'h1f, 7'h3f, 7'h7f};
    typedef enum logic [1:0] {GAIN_NONE, GAIN_1X, GAIN_10X, GAIN_200X} gain_t;
    typedef enum logic [1:0] {SRC_PIN, SRC_BANDGAP, SRC_GROUND} source_t;
    typedef enum logic {CONV_IDLE, CONV_RUN} conv_t;
    typedef struct packed {
        logic start;
        logic first;
        logic differential;
        source_t source;
        logic [2:0] pos;
        logic [2:0] neg;
        gain_t gain;
    } core_req_t;
    typedef struct packed {
        logic on;
        logic auto_on;
        logic flag;
        logic irq_on;
        logic [2:0] div;
        logic left;
        logic [4:0] sel;
        logic [2:0] trig_src;
        conv_t conv;
        logic first;
        logic [4:0] ticks;
        logic [4:0] len;
        logic [4:0] sel_act;
        core_req_t req;
        logic [9:0] result;
        logic lock;
        logic trig_prev;
        logic [31:0] rdata;
    } ctl_state_t;
endpackage

/* verilog/adc_sync2.sv */
// two-flop synchroniser for a group of levels
module adc_sync2 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

/* verilog/adc_clk_div.sv */
// prescaler producing the converter clock as a one-cycle enable
module adc_clk_div
    import adc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] div_sel,
    output logic tick
);
    logic [6:0] count_r;
    logic [6:0] count_nxt;
    assign tick = run && (count_r >= DIV_LAST[div_sel]);
    always_comb begin
        count_nxt = count_r + 7'h01;
        if (!run || tick) begin
            count_nxt = '0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule

/* verilog/adc_ctrl.sv */
// converter control, channel select and result registers behind APB
// Functional notes
// - select field changes apply only after the running conversion completes
// - codes 0..7 single-ended inputs, 0x1e bandgap, 0x1f ground
// - 0x08..0x0f differential at 10x/200x, 0x10..0x1d against input 1 or 2 at 1x
// - converter on powers up; clearing it aborts a running conversion
// - writing start begins a conversion; free-running needs only the first
// - first conversion after enabling lasts 25 converter cycles, later ones 13
// - start reads one while converting; writing zero to it does nothing
// - with auto trigger on, a rising edge of the chosen trigger starts one
// - done flag sets when a conversion ends, also when a lock keeps the results from loading
// - done flag clears on interrupt acknowledge or a written one only
// - interrupt requested while flag, its enable and global enable are set
// - divider codes 0,1 divide by 2, then 4 up to 128
// - after a low byte read the result is frozen until the high byte is read
// - right or left alignment of the ten-bit result over two bytes
// - differential results are two's complement
// - trigger source has no effect while auto trigger is off
// - selecting free-running source produces no trigger edge by itself
// - alignment change shows at once in the result registers
//
// Local design decision: the APB slave port.
module adc_ctrl
    import adc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] trigger_in,
    input wire logic irq_ack,
    input wire logic global_irq_on,
    output logic irq,
    output logic core_on,
    output logic core_tick,
    output core_req_t core_req,
    input wire logic [9:0] core_result
);
    logic rst_meta_r;
    logic rst_n;
    logic [6:0] trig_sync;
    logic [7:0] trig_levels;
    logic tick;
    logic done_evt;
    logic sw_start;
    logic trig_edge;
    logic trig_level;
    logic mapped;
    logic wr_ctrl;
    logic wr_chan;
    logic wr_trig;
    logic rd_lo;
    logic rd_hi;
    logic lo_pending;
    logic flag_clear;
    logic [7:0] res_lo_view;
    logic [7:0] res_hi_view;
    ctl_state_t st_r;
    ctl_state_t st_nxt;

    // reset is asserted at once and released through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    adc_sync2 #(.W(7)) trig_sync_i (
        .clock(clock),
        .rst_n(rst_n),
        .din(trigger_in),
        .dout(trig_sync)
    );

    adc_clk_div div_i (
        .clock(clock),
        .rst_n(rst_n),
        .run(st_r.on),
        .div_sel(st_r.div),
        .tick(tick)
    );

    // channel decode for the analog core
    function automatic core_req_t decode(input logic [4:0] sel);
        core_req_t r;
        r = '0;
        r.source = SRC_PIN;
        r.gain = GAIN_NONE;
        if (sel <= SEL_SE_LAST) begin
            r.pos = sel[2:0];
        end else if (sel <= SEL_GAIN_LAST) begin
            r.differential = 1'b1;
            r.neg = sel[2] ? PIN_2 : PIN_0;
            r.pos = r.neg + {2'h0, sel[0]};
            r.gain = sel[1] ? GAIN_200X : GAIN_10X;
        end else if (sel == SEL_BANDGAP) begin
            r.source = SRC_BANDGAP;
        end else if (sel == SEL_GROUND) begin
            r.source = SRC_GROUND;
        end else begin
            r.differential = 1'b1;
            r.pos = sel[2:0];
            r.neg = (sel <= SEL_NEG1_LAST) ? PIN_1 : PIN_2;
            r.gain = GAIN_1X;
        end
        return r;
    endfunction

    // source 0 is free-running and contributes a level of zero
    assign trig_levels = {trig_sync, 1'b0};
    assign trig_level = trig_levels[st_r.trig_src];
    assign trig_edge = st_r.auto_on && trig_level && !st_r.trig_prev;

    assign mapped = (paddr == ADDR_RES_LO) || (paddr == ADDR_RES_HI) ||
                    (paddr == ADDR_CTRL) || (paddr == ADDR_TRIG) ||
                    (paddr == ADDR_CHAN);
    assign wr_ctrl = psel && penable && pwrite && (paddr == ADDR_CTRL);
    assign wr_chan = psel && penable && pwrite && (paddr == ADDR_CHAN);
    assign wr_trig = psel && penable && pwrite && (paddr == ADDR_TRIG);
    assign rd_lo = psel && penable && !pwrite && (paddr == ADDR_RES_LO);
    assign rd_hi = psel && penable && !pwrite && (paddr == ADDR_RES_HI);
    // a low-byte read already in setup freezes the result, so data and lock agree
    assign lo_pending = psel && !pwrite && (paddr == ADDR_RES_LO);
    assign sw_start = wr_ctrl && pwdata[CTRL_START] && pwdata[CTRL_ON];
    assign flag_clear = irq_ack || (wr_ctrl && pwdata[CTRL_FLAG]);
    assign done_evt = (st_r.conv == CONV_RUN) && st_r.on && tick &&
                      (st_r.ticks == st_r.len - 5'h01);

    // alignment applies to the stored result at read time
    always_comb begin
        if (st_r.left) begin
            res_hi_view = st_r.result[9:2];
            res_lo_view = {st_r.result[1:0], 6'h00};
        end else begin
            res_hi_view = {6'h00, st_r.result[9:8]};
            res_lo_view = st_r.result[7:0];
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.req.start = 1'b0;
        st_nxt.trig_prev = trig_level;
        if (wr_ctrl) begin
            st_nxt.on = pwdata[CTRL_ON];
            st_nxt.auto_on = pwdata[CTRL_AUTO];
            st_nxt.irq_on = pwdata[CTRL_IRQ];
            st_nxt.div = pwdata[DIV_MSB:DIV_LSB];
            if (pwdata[CTRL_ON] && !st_r.on) begin
                st_nxt.first = 1'b1;
            end
        end
        if (wr_chan) begin
            st_nxt.left = pwdata[CHAN_LEFT];
            st_nxt.sel = pwdata[SEL_MSB:SEL_LSB];
        end
        if (wr_trig) begin
            st_nxt.trig_src = pwdata[TRIG_MSB:0];
        end
        if (rd_lo) begin
            st_nxt.lock = 1'b1;
        end
        if (rd_hi) begin
            st_nxt.lock = 1'b0;
        end
        if (st_r.conv == CONV_RUN && tick) begin
            st_nxt.ticks = st_r.ticks + 5'h01;
        end
        if (done_evt) begin
            st_nxt.conv = CONV_IDLE;
            if (!st_r.lock && !lo_pending) begin
                st_nxt.result = core_result;
                if (st_r.req.differential) begin
                    st_nxt.result[9] = ~core_result[9];
                end
            end
        end
        // set wins over clear
        st_nxt.flag = (st_r.flag && !flag_clear) || done_evt;
        if ((st_nxt.conv == CONV_IDLE) && st_nxt.on &&
            (sw_start || trig_edge ||
             (done_evt && st_r.auto_on && st_r.trig_src == TRIG_FREE))) begin
            st_nxt.conv = CONV_RUN;
            st_nxt.ticks = '0;
            st_nxt.len = st_nxt.first ? FIRST_CYCLES : NORMAL_CYCLES;
            st_nxt.first = 1'b0;
            st_nxt.sel_act = st_nxt.sel;
            st_nxt.req = decode(st_nxt.sel);
            st_nxt.req.first = st_nxt.first ^ (st_nxt.len == FIRST_CYCLES);
            st_nxt.req.start = 1'b1;
        end
        if (!st_nxt.on) begin
            st_nxt.conv = CONV_IDLE;
        end
        if (psel && !penable && !pwrite) begin
            st_nxt.rdata = '0;
            case (paddr)
                ADDR_RES_LO: st_nxt.rdata[7:0] = res_lo_view;
                ADDR_RES_HI: st_nxt.rdata[7:0] = res_hi_view;
                ADDR_CTRL: st_nxt.rdata[7:0] = {st_r.on, st_r.conv == CONV_RUN,
                    st_r.auto_on, st_r.flag, st_r.irq_on, st_r.div};
                ADDR_TRIG: st_nxt.rdata[TRIG_MSB:0] = st_r.trig_src;
                ADDR_CHAN: st_nxt.rdata[7:0] = {2'h0, st_r.left, st_r.sel};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // zero-wait slave: data loaded in setup, answered in the access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st_r.rdata;
    assign irq = st_r.flag && st_r.irq_on && global_irq_on;
    assign core_on = st_r.on;
    assign core_tick = tick && st_r.on;
    assign core_req = st_r.req;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_SEL_HELD: assert property ((st_r.conv == CONV_RUN) && !done_evt && st_r.on
        |=> $stable(st_r.sel_act) && $stable(core_req.pos))
        else $error("channel changed during conversion");
    AST_GROUND: assert property (core_req.start && (st_r.sel_act == SEL_GROUND)
        |-> core_req.source == SRC_GROUND)
        else $error("ground code not routed");
    AST_GAIN: assert property (core_req.start && (st_r.sel_act[4:3] == 2'b01)
        |-> core_req.differential && (core_req.gain == (st_r.sel_act[1] ?
            GAIN_200X : GAIN_10X)))
        else $error("gain decode wrong");
    AST_OFF_ABORT: assert property (wr_ctrl && !pwdata[CTRL_ON]
        |=> (st_r.conv == CONV_IDLE) && !core_on)
        else $error("conversion survived power off");
    AST_LEN: assert property (sw_start && st_r.on && (st_r.conv == CONV_IDLE)
        && !st_r.first |=> core_req.start && (st_r.len == NORMAL_CYCLES))
        else $error("wrong conversion length");
    AST_FIRST: assert property (wr_ctrl && pwdata[CTRL_ON] && pwdata[CTRL_START]
        && !st_r.on |=> core_req.start && (st_r.len == FIRST_CYCLES))
        else $error("first conversion not long");
    AST_BUSY_READ: assert property (psel && !penable && !pwrite &&
        (paddr == ADDR_CTRL) |=> prdata[CTRL_START] == $past(st_r.conv == CONV_RUN))
        else $error("start bit does not show busy");
    AST_FLAG_SET: assert property (done_evt |=> st_r.flag && (st_r.conv == CONV_IDLE ||
        core_req.start))
        else $error("done flag not set");
    AST_FLAG_HOLD: assert property (st_r.flag && !flag_clear |=> st_r.flag)
        else $error("done flag lost");
    AST_IRQ: assert property (done_evt && st_r.irq_on && !wr_ctrl
        |=> irq == global_irq_on)
        else $error("interrupt not requested");
    AST_LOCK: assert property (st_r.lock && !rd_hi |=> $stable(st_r.result))
        else $error("result changed while locked");
    AST_NO_AUTO: assert property (!st_r.auto_on && !sw_start && (st_r.conv == CONV_IDLE)
        |=> !core_req.start)
        else $error("start without request");

    COV_FIRST: cover property (done_evt && (st_r.len == FIRST_CYCLES));
    COV_LOCKED_DROP: cover property (done_evt && st_r.lock);
    COV_AUTO: cover property (trig_edge && (st_r.conv == CONV_IDLE) && st_r.on);
    COV_FREE: cover property (done_evt && st_r.auto_on && (st_r.trig_src == TRIG_FREE));
endmodule

/* testbench/adc_core_model.sv */
// behavioural analog core that answers with a channel-coded result
module adc_core_model
    import adc_pkg::*;
(
    input wire logic clock,
    input wire logic core_on,
    input wire logic core_tick,
    input wire core_req_t core_req,
    output logic [9:0] core_result
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] val_r = 10'h000;
    logic [4:0] left_r = 5'h00;
    always @(posedge clock) begin
        if (!core_on) begin
            left_r <= 5'h00;
        end else if (core_req.start) begin
            // one spare tick so a block that samples late still sees the value
            left_r <= (core_req.first ? FIRST_CYCLES : NORMAL_CYCLES) + 5'h01;
            val_r <= {core_req.differential ? 2'(core_req.gain) : 2'(core_req.source),
                      core_req.source == SRC_PIN ? core_req.pos : 3'h0,
                      core_req.differential ? core_req.neg : 3'h0,
                      core_req.differential, 1'b1};
        end else if (core_tick && left_r != 5'h00) begin
            left_r <= left_r - 5'h01;
        end
    end
    // outside a conversion the value is not held, so a late sample shows up
    assign core_result = (left_r != 5'h00) ? val_r : ~val_r;
endmodule

/* testbench/test_adc_ctrl.sv */
// self-checking bench of the converter control block
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    $display("FAIL %s exp %0h got %0h", nm, e, g); num_errors++; end end
module test_adc_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, core_on, core_tick, err_r, lf;
    logic [6:0] trigger_in = 7'h00;
    logic irq_ack = 1'b0;
    logic global_irq_on = 1'b1;
    core_req_t core_req;
    logic [9:0] core_result;
    logic [31:0] rd_r;
    int num_errors = 0;
    int check_count = 0;
    int n;
    int seed = 32'h9e13;
    always #2 clock = ~clock;
    adc_ctrl uut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
        .irq_ack(irq_ack), .global_irq_on(global_irq_on), .irq(irq),
        .core_on(core_on), .core_tick(core_tick), .core_req(core_req),
        .core_result(core_result));
    adc_core_model far (.clock(clock), .core_on(core_on), .core_tick(core_tick),
        .core_req(core_req), .core_result(core_result));
    function automatic logic [9:0] exp_res(input logic [4:0] s);
        logic [1:0] g;
        logic [2:0] p;
        logic [2:0] q;
        logic d;
        d = s > 5'h07 && s < 5'h1e;
        g = 2'(SRC_PIN);
        p = s[2:0];
        q = 3'h0;
        if (!d && s[4]) begin
            g = s[0] ? 2'(SRC_GROUND) : 2'(SRC_BANDGAP);
            p = 3'h0;
        end else if (s[4]) begin
            g = 2'(GAIN_1X);
            q = s[3] ? 3'h2 : 3'h1;
        end else if (d) begin
            g = s[1] ? 2'(GAIN_200X) : 2'(GAIN_10X);
            p = {1'b0, s[2], s[0]};
            q = s[2] ? 3'h2 : 3'h0;
        end
        exp_res = {g, p, q, d, 1'b1} ^ {d, 9'h000};
    endfunction
    function automatic logic [15:0] split(input logic [9:0] r, input logic l);
        split = l ? {r[9:2], r[1:0], 6'h00} : {6'h00, r};
    endfunction
    function automatic logic inr(input int len, input int div);
        inr = n >= len * div - div && n <= len * div + div + 4;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd_r = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(nm, e, rd_r[7:0])
    endtask
    task automatic chk_res(input logic [15:0] e);
        chk_rd("result_low_byte", ADDR_RES_LO, e[7:0]);
        chk_rd("result_high_byte", ADDR_RES_HI, e[15:8]);
    endtask
    task automatic wait_irq();
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (irq !== 1'b1 && n < 5000);
        `CHK("irq_wait", 1'b1, irq)
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    // control writes are whole values, never read back and modified
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 5; i++) chk_rd("reset", ADDR_RES_LO + 12'(4 * i), 8'h00);
        chk_rd("unmapped", 12'h000, 8'h00);
        `CHK("pslverr", 1'b1, err_r)
        $display("test reset done");
        for (int s = 0; s < 32; s++) begin
            lf = 1'($random(seed));
            apb(1'b1, ADDR_CHAN, {2'h0, lf, 5'(s)});
            apb(1'b1, ADDR_CTRL, 8'hd8 | 8'($random(seed) & 1));
            wait_irq();
            if (s < 2) `CHK("conv_len", 1'b1, inr(s ? 13 : 25, 2))
            chk_res(split(exp_res(5'(s)), lf));
            apb(1'b1, ADDR_CHAN, {2'h0, ~lf, 5'(s)});
            chk_res(split(exp_res(5'(s)), ~lf));
        end
        $display("test channels done");
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, ADDR_CTRL, 8'hd8 | 8'(d));
            wait_irq();
            `CHK("conv_len", 1'b1, inr(13, d < 2 ? 2 : 1 << d))
        end
        $display("test divider done");
        apb(1'b1, ADDR_CHAN, 8'h03);
        apb(1'b1, ADDR_CTRL, 8'hd9);
        apb(1'b1, ADDR_CHAN, 8'h05);
        apb(1'b1, ADDR_CTRL, 8'h99);
        chk_rd("control", ADDR_CTRL, 8'hc9);
        wait_irq();
        chk_res(split(exp_res(5'h03), 1'b0));
        apb(1'b1, ADDR_CTRL, 8'hd9);
        wait_irq();
        chk_res(split(exp_res(5'h05), 1'b0));
        apb(1'b1, ADDR_CHAN, 8'h1e);
        apb(1'b0, ADDR_RES_LO, 8'h00);
        apb(1'b1, ADDR_CTRL, 8'hd9);
        wait_irq();
        chk_res(split(exp_res(5'h05), 1'b0));
        $display("test deferral and lock done");
        global_irq_on <= 1'b0;
        @(posedge clock) #1;
        `CHK("irq", 1'b0, irq)
        @(posedge clock) global_irq_on <= 1'b1;
        apb(1'b1, ADDR_CTRL, 8'h89);
        #1;
        `CHK("irq", 1'b1, irq)
        @(posedge clock) irq_ack <= 1'b1;
        @(posedge clock) irq_ack <= 1'b0;
        #1;
        `CHK("irq", 1'b0, irq)
        $display("test flag done");
        apb(1'b1, ADDR_CTRL, 8'hdf);
        repeat (50) @(posedge clock);
        apb(1'b1, ADDR_CTRL, 8'h00);
        repeat (2000) @(posedge clock);
        `CHK("core_on", 1'b0, core_on)
        chk_rd("control", ADDR_CTRL, 8'h00);
        $display("test abort done");
        apb(1'b1, ADDR_TRIG, 8'h03);
        apb(1'b1, ADDR_CTRL, 8'h98);
        @(posedge clock) trigger_in <= 7'h04;
        repeat (40) @(posedge clock);
        chk_rd("control", ADDR_CTRL, 8'h88);
        @(posedge clock) trigger_in <= 7'h00;
        apb(1'b1, ADDR_CTRL, 8'hb8);
        trigger_in <= 7'h04;
        wait_irq();
        `CHK("irq", 1'b1, irq)
        apb(1'b1, ADDR_TRIG, 8'h00);
        chk_rd("control", ADDR_CTRL, 8'hb8);
        apb(1'b1, ADDR_CTRL, 8'hf8);
        wait_irq();
        chk_rd("control", ADDR_CTRL, 8'hf8);
        $display("test auto trigger done");
        // reset in the middle of free-running conversions
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK("irq", 1'b0, irq)
        chk_rd("reset", ADDR_CTRL, 8'h00);
        apb(1'b1, ADDR_CTRL, 8'h00);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
